// >>> rtl/cmcrc_checker.sv
// Configuration memory CRC checker: frame CRC during load, full CRC in user mode
`timescale 1ns/1ps
`include "cmcrc_params.svh"
//
// Contract
// - Error flag high when cell corruption found
// - Error flag open-drain, only when enabled
// - One 32-bit CRC covers all cells
// - Each config frame carries 16-bit CRC
// - Shift in frame CRC, compute in parallel
// - Frame CRC mismatch drives status line low
// - Frame length is a parameter
// - Result register holds computed versus reference
// - No corruption leaves result all zeros
// - Flag high when any result bit set
// - Load reference at configuration end
// - Rewrite instruction makes reference a shift chain
// - Reference shifting never stops checking
// - Rewrite instruction decoded from 10-bit code
// - Checking repeats until reconfig request low
// - Flag holds through next pass
// - Check rate is clock over 2^n, n capped at 8
module cmcrc_checker
    import cmcrc_pkg::*;
#(
    parameter int FRAME_BITS = `CMCRC_FRAME_BITS
) (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       reconfig_request_n,
    input  wire logic                       crc_check_enable,
    input  wire logic [`CMCRC_DIVSEL_W-1:0] div_sel,
    input  wire logic                       cfg_bit_valid,
    input  wire logic                       cfg_bit,
    input  wire logic                       cfg_done,
    input  wire logic [`CMCRC_SIG_W-1:0]    cfg_ref_value,
    output logic [`CMCRC_ADDR_W-1:0]        cell_addr,
    input  wire logic [`CMCRC_SIG_W-1:0]    cell_data,
    input  wire logic [`CMCRC_INSTR_W-1:0]  scan_instr,
    input  wire logic                       scan_shift,
    input  wire logic                       scan_tdi,
    output logic                            scan_tdo,
    output logic [`CMCRC_SIG_W-1:0]         crc_check_result,
    output logic                            crc_error_out,
    output logic                            crc_error_oe_n,
    output logic                            config_status_out,
    output logic                            config_status_oe_n,
    output logic                            user_mode
);

    cmcrc_state_t st_ff;
    cmcrc_state_t nxt_st;

    function automatic logic [`CMCRC_SIG_W-1:0] crc32_word(
        input logic [`CMCRC_SIG_W-1:0] crc_in,
        input logic [`CMCRC_SIG_W-1:0] data
    );
        logic [`CMCRC_SIG_W-1:0] c;
        c = crc_in;
        for (int i = `CMCRC_SIG_W - 1; i >= 0; i--) begin
            if (c[`CMCRC_SIG_W-1] ^ data[i]) begin
                c = {c[`CMCRC_SIG_W-2:0], 1'b0} ^ `CMCRC_POLY32;
            end else begin
                c = {c[`CMCRC_SIG_W-2:0], 1'b0};
            end
        end
        return c;
    endfunction

    function automatic logic [`CMCRC_FCRC_W-1:0] crc16_bit(
        input logic [`CMCRC_FCRC_W-1:0] crc_in,
        input logic                     d
    );
        if (crc_in[`CMCRC_FCRC_W-1] ^ d) begin
            return {crc_in[`CMCRC_FCRC_W-2:0], 1'b0} ^ `CMCRC_POLY16;
        end
        return {crc_in[`CMCRC_FCRC_W-2:0], 1'b0};
    endfunction

    function automatic logic [`CMCRC_DIV_W-1:0] div_mask(
        input logic [`CMCRC_DIVSEL_W-1:0] sel
    );
        logic [`CMCRC_DIVSEL_W-1:0] s;
        s = (sel > `CMCRC_DIVSEL_MAX) ? `CMCRC_DIVSEL_MAX : sel;
        return `CMCRC_DIV_W'((9'h001 << s) - 9'h001);
    endfunction

    localparam logic [`CMCRC_FCNT_W-1:0] FRAME_END =
        `CMCRC_FCNT_W'(FRAME_BITS + `CMCRC_FCRC_W - 1);
    localparam logic [`CMCRC_FCNT_W-1:0] FRAME_DATA_END = `CMCRC_FCNT_W'(FRAME_BITS);

    logic                    tick;
    logic                    pass_end;
    logic                    rewrite_shift;
    logic                    frame_last;
    logic                    frame_bad;
    logic [`CMCRC_SIG_W-1:0] crc_final;

    always_comb begin
        // One-cycle enable every 2^n clocks; the counter only runs in user mode
        tick          = (st_ff.div_cnt & div_mask(div_sel)) == div_mask(div_sel);
        pass_end      = tick && st_ff.phase == CMCRC_PH_USER
                        && st_ff.addr == `CMCRC_LAST_ADDR;
        rewrite_shift = scan_shift && st_ff.phase == CMCRC_PH_USER
                        && scan_instr == `CMCRC_REWRITE_INSTR;
        frame_last    = cfg_bit_valid && st_ff.phase == CMCRC_PH_CONFIG
                        && st_ff.fcnt == FRAME_END;
        // Last received CRC bit joins the compare in the cycle it arrives
        frame_bad     = frame_last && st_ff.fcrc != {st_ff.frx[`CMCRC_FCRC_W-2:0], cfg_bit};
        crc_final     = crc32_word(st_ff.crc, cell_data);
    end

    always_comb begin
        nxt_st = st_ff;
        if (!reconfig_request_n) begin
            // Reconfiguration stops checking and clears every result
            nxt_st             = '0;
            nxt_st.phase       = CMCRC_PH_CONFIG;
            nxt_st.crc         = `CMCRC_INIT32;
            nxt_st.fcrc        = `CMCRC_INIT16;
            nxt_st.err_oe_n    = 1'b1;
            nxt_st.status_oe_n = 1'b1;
        end else begin
            unique case (st_ff.phase)
                CMCRC_PH_CONFIG: begin
                    if (cfg_bit_valid) begin
                        if (st_ff.fcnt < FRAME_DATA_END) begin
                            nxt_st.fcrc = crc16_bit(st_ff.fcrc, cfg_bit);
                        end else begin
                            nxt_st.frx = {st_ff.frx[`CMCRC_FCRC_W-2:0], cfg_bit};
                        end
                        if (frame_last) begin
                            nxt_st.fcnt = '0;
                            nxt_st.fcrc = `CMCRC_INIT16;
                        end else begin
                            nxt_st.fcnt = st_ff.fcnt + 1'b1;
                        end
                    end
                    if (frame_bad) begin
                        nxt_st.status_oe_n = 1'b0;
                    end
                    if (cfg_done && st_ff.status_oe_n && !frame_bad) begin
                        nxt_st.ref_val = cfg_ref_value;
                        nxt_st.phase   = CMCRC_PH_USER;
                        nxt_st.addr    = '0;
                        nxt_st.crc     = `CMCRC_INIT32;
                        nxt_st.div_cnt = '0;
                    end
                end
                CMCRC_PH_USER: begin
                    nxt_st.div_cnt = st_ff.div_cnt + 1'b1;
                    if (tick) begin
                        nxt_st.div_cnt = '0;
                        nxt_st.addr    = st_ff.addr + 1'b1;
                        nxt_st.crc     = crc_final;
                    end
                    if (pass_end) begin
                        nxt_st.sig  = crc_final ^ st_ff.ref_val;
                        nxt_st.addr = '0;
                        nxt_st.crc  = `CMCRC_INIT32;
                    end
                    if (rewrite_shift) begin
                        // Shifting runs beside the pass; the next compare uses the new value
                        nxt_st.ref_val = {scan_tdi, st_ff.ref_val[`CMCRC_SIG_W-1:1]};
                    end
                end
            endcase
            // Released pin reads high through the pull-up, so released means error or crc_check_enable low
            nxt_st.err_oe_n = !crc_check_enable || (|nxt_st.sig);
        end
        nxt_st.tdo = nxt_st.ref_val[0];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff             <= '0;
            st_ff.phase       <= CMCRC_PH_CONFIG;
            st_ff.crc         <= `CMCRC_INIT32;
            st_ff.fcrc        <= `CMCRC_INIT16;
            st_ff.err_oe_n    <= 1'b1;
            st_ff.status_oe_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        cell_addr          = st_ff.addr;
        scan_tdo           = st_ff.tdo;
        crc_check_result   = st_ff.sig;
        crc_error_out      = 1'b0;
        crc_error_oe_n     = st_ff.err_oe_n;
        config_status_out  = 1'b0;
        config_status_oe_n = st_ff.status_oe_n;
        user_mode          = st_ff.phase == CMCRC_PH_USER;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Error flag and result register
    flag_from_sig_a: assert property (
        user_mode && crc_check_enable && $stable(crc_check_enable)
        |-> crc_error_oe_n == (|crc_check_result))
        else $error("error flag disagrees with result register");

    flag_disabled_a: assert property (
        !crc_check_enable && reconfig_request_n |=> crc_error_oe_n)
        else $error("error flag driven while feature disabled");

    sig_hold_a: assert property (
        !$stable(crc_check_result) |-> $past(pass_end) || !$past(reconfig_request_n))
        else $error("result changed outside a pass end");

    match_zero_a: assert property (
        pass_end && reconfig_request_n && crc_final == st_ff.ref_val
        |=> crc_check_result == '0)
        else $error("matching pass left nonzero result");

    // Reconfiguration and pass sequencing
    reconfig_stop_a: assert property (
        !reconfig_request_n |=> !user_mode && cell_addr == '0 && crc_check_result == '0)
        else $error("checking not stopped by reconfiguration request");

    user_stay_a: assert property (
        user_mode && reconfig_request_n |=> user_mode)
        else $error("checking stopped without reconfiguration request");

    pass_restart_a: assert property (
        pass_end && reconfig_request_n |=> cell_addr == '0 && st_ff.crc == `CMCRC_INIT32)
        else $error("pass did not restart");

    pass_start_a: assert property (
        $rose(user_mode) |-> cell_addr == '0 && st_ff.crc == `CMCRC_INIT32)
        else $error("first pass did not start from the initial state");

    // Reference load and scan chain
    ref_load_a: assert property (
        !user_mode && cfg_done && reconfig_request_n && config_status_oe_n && !frame_bad
        |=> user_mode && st_ff.ref_val == $past(cfg_ref_value))
        else $error("reference not loaded at configuration end");

    scan_chain_a: assert property (
        rewrite_shift && reconfig_request_n
        |=> st_ff.ref_val == {$past(scan_tdi), $past(st_ff.ref_val[31:1])}
            && scan_tdo == $past(st_ff.ref_val[1]))
        else $error("reference chain did not shift");

    ref_refuse_a: assert property (
        user_mode && scan_shift && scan_instr != `CMCRC_REWRITE_INSTR && reconfig_request_n
        |=> $stable(st_ff.ref_val))
        else $error("reference shifted under another instruction");

    scan_run_a: assert property (
        rewrite_shift && reconfig_request_n && tick |=> user_mode
            && cell_addr == $past(cell_addr) + 1'b1)
        else $error("shifting stalled the pass");

    // Frame check during configuration
    frame_err_a: assert property (
        $fell(config_status_oe_n) |-> $past(frame_bad))
        else $error("status pulled low without frame mismatch");

    frame_ok_a: assert property (
        frame_last && !frame_bad && config_status_oe_n && reconfig_request_n
        |=> config_status_oe_n)
        else $error("status pulled low on matching frame");

    frame_sticky_a: assert property (
        !config_status_oe_n && reconfig_request_n |=> !config_status_oe_n)
        else $error("frame error released before reconfiguration");

    done_refused_a: assert property (
        !user_mode && !config_status_oe_n && cfg_done && reconfig_request_n |=> !user_mode)
        else $error("user mode entered after frame error");

    cfg_ignored_a: assert property (
        user_mode && cfg_bit_valid && reconfig_request_n
        |=> $stable(st_ff.fcnt) && config_status_oe_n)
        else $error("stream bit taken in user mode");

    // Check rate
    div_rate0_a: assert property (
        disable iff (!reset_n || !reconfig_request_n)
        user_mode && div_sel == 4'h0 |=> cell_addr == $past(cell_addr) + 1'b1)
        else $error("undivided rate wrong");

    div_rate_a: assert property (
        disable iff (!reset_n || !reconfig_request_n)
        user_mode && tick && div_sel == 4'h1 && $stable(div_sel) |=> !tick ##1 tick)
        else $error("divide by two rate wrong");

    div_rate2_a: assert property (
        disable iff (!reset_n || !reconfig_request_n)
        user_mode && tick && div_sel == 4'h2 && $stable(div_sel) |=> !tick [*3] ##1 tick)
        else $error("divide by four rate wrong");

    pass_error_c: cover property (pass_end ##1 (|crc_check_result));
    frame_bad_c:  cover property (frame_bad);
    rewrite_c:    cover property (rewrite_shift [*8]);
    user_entry_c: cover property (!user_mode ##1 user_mode);
    div_tick_c:   cover property (user_mode && tick && div_sel != 4'h0);

endmodule

// >>> rtl/cmcrc_params.svh
// Constants for the configuration memory CRC checker
`ifndef CMCRC_PARAMS_SVH
`define CMCRC_PARAMS_SVH
`define CMCRC_SIG_W          32
`define CMCRC_FCRC_W         16
`define CMCRC_POLY32         32'h04C11DB7
`define CMCRC_INIT32         32'hFFFFFFFF
`define CMCRC_POLY16         16'h8005
`define CMCRC_INIT16         16'h0000
`define CMCRC_INSTR_W        10
`define CMCRC_REWRITE_INSTR  10'h015
`define CMCRC_CELL_WORDS     64
`define CMCRC_ADDR_W         6
`define CMCRC_LAST_ADDR      6'h3F
`define CMCRC_FRAME_BITS     128
`define CMCRC_FCNT_W         16
`define CMCRC_DIV_W          8
`define CMCRC_DIVSEL_W       4
`define CMCRC_DIVSEL_MAX     4'h8
`endif

// >>> rtl/cmcrc_pkg.sv
// Types for the configuration memory CRC checker
`include "cmcrc_params.svh"
package cmcrc_pkg;
    typedef enum logic {
        CMCRC_PH_CONFIG,
        CMCRC_PH_USER
    } cmcrc_phase_t;

    typedef struct packed {
        cmcrc_phase_t              phase;
        logic [`CMCRC_DIV_W-1:0]   div_cnt;
        logic [`CMCRC_ADDR_W-1:0]  addr;
        logic [`CMCRC_SIG_W-1:0]   crc;
        logic [`CMCRC_SIG_W-1:0]   ref_val;
        logic [`CMCRC_SIG_W-1:0]   sig;
        logic                      err_oe_n;
        logic                      status_oe_n;
        logic [`CMCRC_FCNT_W-1:0]  fcnt;
        logic [`CMCRC_FCRC_W-1:0]  fcrc;
        logic [`CMCRC_FCRC_W-1:0]  frx;
        logic                      tdo;
    } cmcrc_state_t;
endpackage

// >>> verif/cmcrc_monitor.sv
// System monitor model that resolves the open-drain flag and status lines
`timescale 1ns/1ps
module cmcrc_monitor (
    input  wire logic clk,
    input  wire logic crc_error_out,
    input  wire logic crc_error_oe_n,
    input  wire logic config_status_out,
    input  wire logic config_status_oe_n,
    output logic      err_line,
    output logic      status_line
);
    // Pull-ups win whenever the device releases a line
    always_ff @(posedge clk) begin
        err_line    <= crc_error_oe_n ? 1'b1 : crc_error_out;
        status_line <= config_status_oe_n ? 1'b1 : config_status_out;
    end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the configuration memory CRC checker
`timescale 1ns/1ps
`include "cmcrc_params.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("Error t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    import cmcrc_pkg::*;
    localparam int FB = 16;
    logic        clk = 0, reset_n = 0, rq_n = 1, en = 1, v = 0, b = 0, done = 0;
    logic        sh = 0, tdi = 0, tdo, eo, eoe, so, soe, um, err_line, st_line;
    logic [3:0]  dsel = 4'h0;
    logic [9:0]  ins = 10'h000;
    logic [5:0]  addr;
    logic [31:0] refv = 32'h0, res, nv, lf = 32'h3BD421E4;
    logic [31:0] mem [64];
    logic [FB-1:0] d;
    int          fails = 0, checks = 0, k, j;

    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    function automatic logic [31:0] crc32();
        logic [31:0] c = `CMCRC_INIT32;
        for (int w = 0; w < 64; w++)
            for (int i = 31; i >= 0; i--)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ mem[w][i]) ? `CMCRC_POLY32 : 32'h0);
        return c;
    endfunction
    function automatic logic [15:0] crc16(input logic [FB-1:0] x);
        logic [15:0] c = `CMCRC_INIT16;
        for (int i = FB - 1; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ x[i]) ? `CMCRC_POLY16 : 16'h0);
        return c;
    endfunction

    cmcrc_checker #(.FRAME_BITS(FB)) dut_u (.clk(clk), .reset_n(reset_n),
        .reconfig_request_n(rq_n), .crc_check_enable(en), .div_sel(dsel),
        .cfg_bit_valid(v), .cfg_bit(b), .cfg_done(done), .cfg_ref_value(refv),
        .cell_addr(addr), .cell_data(mem[addr]), .scan_instr(ins), .scan_shift(sh),
        .scan_tdi(tdi), .scan_tdo(tdo), .crc_check_result(res), .crc_error_out(eo),
        .crc_error_oe_n(eoe), .config_status_out(so), .config_status_oe_n(soe),
        .user_mode(um));
    cmcrc_monitor mon_u (.clk(clk), .crc_error_out(eo), .crc_error_oe_n(eoe),
        .config_status_out(so), .config_status_oe_n(soe), .err_line(err_line),
        .status_line(st_line));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic frame(input logic [FB-1:0] x, input logic bad);
        logic [15:0] c;
        c = crc16(x) ^ {15'h0, bad};
        for (int i = 0; i < FB + 16; i++) begin
            @(negedge clk);
            v = 1'b1;
            b = (i < FB) ? x[FB-1-i] : c[FB+15-i];
        end
        @(negedge clk);
        v = 1'b0;
        @(negedge clk);
    endtask
    task automatic shift(input logic t);
        @(negedge clk);
        sh = 1'b1;
        tdi = t;
    endtask
    task automatic pass_wait();
        repeat (2 * 64 * (1 << dsel) + 8) @(negedge clk);
    endtask
    task automatic complete_run();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 64; i++) mem[i] = rnd();
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        `CHK({res, eoe, soe, um}, {32'h0, 3'b110})
        dsel = 4'(rnd() % 3);
        d = FB'(rnd());
        frame(d, 1'b0);
        `CHK(soe, 1'b1)
        refv = crc32();
        @(negedge clk) done = 1'b1;
        @(negedge clk) done = 1'b0;
        `CHK(um, 1'b1)
        @(negedge clk) v = 1'b1;
        @(negedge clk) v = 1'b0;
        `CHK({um, soe}, 2'b11)
        pass_wait();
        `CHK({res, err_line}, 33'h0)
        k = rnd() % 64;
        j = rnd() % 32;
        mem[k][j] = ~mem[k][j];
        pass_wait();
        `CHK(res, crc32() ^ refv)
        `CHK(err_line, 1'b1)
        mem[k][j] = ~mem[k][j];
        nv = rnd();
        shift(1'b1);
        @(negedge clk);
        sh = 1'b0;
        `CHK(tdo, refv[0])
        ins = `CMCRC_REWRITE_INSTR;
        for (int i = 0; i < 32; i++) shift(nv[i]);
        @(negedge clk);
        sh = 1'b0;
        `CHK(tdo, nv[0])
        pass_wait();
        `CHK(res, crc32() ^ nv)
        `CHK(um, 1'b1)
        rq_n = 1'b0;
        @(negedge clk) rq_n = 1'b1;
        `CHK(um, 1'b0)
        frame(d, 1'b1);
        `CHK(st_line, 1'b0)
        @(negedge clk) done = 1'b1;
        @(negedge clk) done = 1'b0;
        en = 1'b0;
        @(negedge clk);
        `CHK({um, eoe}, 2'b01)
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule
